// ===== rtl/light_cmp2_regs.svh
// Register map and timing constants of the second light comparator block
`ifndef LIGHT_CMP2_REGS_SVH
`define LIGHT_CMP2_REGS_SVH
`define CFG2_ADDR 8'h1C
`define OFFICE_THR_ADDR 8'h1D
`define CFG2_RESET 8'h00
`define OFFICE_THR_RESET 8'h00
`define FILT_MSB 7
`define FILT_LSB 5
`define FORCE_BIT 4
`define DARK_RES_BIT 3
`define OFFICE_RES_BIT 2
`define DARK_EN_BIT 1
`define OFFICE_EN_BIT 0
`define FILT_BASE_MS 80
`define CLK_KHZ 10000
`define LEVEL_DAY 2'h1
`define LEVEL_OFFICE 2'h2
`define LEVEL_DARK 2'h3
`endif

// ===== rtl/light_cmp2_pkg.sv
// Types of the second light comparator block
package light_cmp2_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } conv_state_t;
endpackage

// ===== rtl/second_light_comparator_cfg.sv
// Second light comparator configuration, filter timing and result logic
`timescale 1ns/1ns
`default_nettype none
`include "light_cmp2_regs.svh"
module second_light_comparator_cfg #(
    parameter int unsigned FILT_BASE_CYCLES = `FILT_BASE_MS * `CLK_KHZ
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic sinks_active_i,
    input wire logic backlight_en_i,
    input wire logic conv_done_i,
    input wire logic [7:0] office_code_i,
    input wire logic [7:0] office_hys_i,
    input wire logic [7:0] dark_code_i,
    input wire logic [7:0] dark_thr_i,
    input wire logic [7:0] dark_hys_i,
    output logic conv_start_o,
    output logic office_cmp_o,
    output logic dark_cmp_o,
    output logic [1:0] backlight_level_o
);
    // Hysteresis comparator: trip below threshold, release above threshold plus hysteresis
    function automatic logic hyst_cmp(input logic res, input logic [7:0] code,
                                      input logic [7:0] thr, input logic [7:0] hys);
        logic [8:0] upper;
        upper = {1'b0, thr} + {1'b0, hys};
        if (!res) begin
            hyst_cmp = (code < thr);
        end else begin
            hyst_cmp = !({1'b0, code} > upper);
        end
    endfunction

    logic [7:0] cfg_q;
    logic [7:0] thr_q;
    logic force_q;
    logic forced_q;
    logic office_res_q;
    logic dark_res_q;
    logic [31:0] cnt_q;
    logic tick_q;
    light_cmp2_pkg::conv_state_t st_q;

    wire wr_cfg = reg_wr_i && (reg_addr_i == `CFG2_ADDR);
    wire wr_thr = reg_wr_i && (reg_addr_i == `OFFICE_THR_ADDR);
    wire [2:0] filt_sel = cfg_q[`FILT_MSB:`FILT_LSB];
    wire office_en = cfg_q[`OFFICE_EN_BIT];
    wire dark_en = cfg_q[`DARK_EN_BIT];
    wire [31:0] filt_limit = FILT_BASE_CYCLES << filt_sel;
    wire cnt_wrap = (cnt_q >= filt_limit - 32'h1);
    wire force_go = force_q && sinks_active_i && !backlight_en_i;
    wire idle = (st_q == light_cmp2_pkg::ST_IDLE);
    wire start_d = idle && (force_go || (tick_q && backlight_en_i));
    wire upd = (st_q == light_cmp2_pkg::ST_CONV) && conv_done_i;
    wire office_nxt = hyst_cmp(office_res_q, office_code_i, thr_q, office_hys_i);
    wire dark_nxt = hyst_cmp(dark_res_q, dark_code_i, dark_thr_i, dark_hys_i);
    wire force_wr = wr_cfg && reg_wdata_i[`FORCE_BIT] && !backlight_en_i;
    wire force_clr = upd && forced_q;
    wire [7:0] cfg_rd = {cfg_q[7:5], force_q, dark_res_q, office_res_q, cfg_q[1:0]};
    wire [7:0] rdata_d = (reg_addr_i == `CFG2_ADDR) ? cfg_rd :
                         (reg_addr_i == `OFFICE_THR_ADDR) ? thr_q : 8'h00;
    wire [1:0] level_d = dark_res_q ? `LEVEL_DARK : (office_res_q ? `LEVEL_OFFICE : `LEVEL_DAY);

    // Register writes
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_q <= `CFG2_RESET;
            thr_q <= `OFFICE_THR_RESET;
        end else begin
            if (wr_cfg) begin
                cfg_q <= reg_wdata_i;
            end
            if (wr_thr) begin
                thr_q <= reg_wdata_i;
            end
        end
    end

    // Force request bit, set wins over clear
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            force_q <= 1'b0;
        end else if (force_wr) begin
            force_q <= 1'b1;
        end else if (force_clr || (wr_cfg && !reg_wdata_i[`FORCE_BIT])) begin
            force_q <= 1'b0;
        end
    end

    // Filter interval timer
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_wrap ? 32'h0 : cnt_q + 32'h1;
            tick_q <= cnt_wrap;
        end
    end

    // Conversion sequencer
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            st_q <= light_cmp2_pkg::ST_IDLE;
            forced_q <= 1'b0;
            conv_start_o <= 1'b0;
        end else begin
            conv_start_o <= start_d;
            unique case (st_q)
                light_cmp2_pkg::ST_IDLE: begin
                    if (start_d) begin
                        st_q <= light_cmp2_pkg::ST_CONV;
                        forced_q <= force_go;
                    end
                end
                light_cmp2_pkg::ST_CONV: begin
                    if (conv_done_i) begin
                        st_q <= light_cmp2_pkg::ST_IDLE;
                        forced_q <= 1'b0;
                    end
                end
                default: begin
                    st_q <= light_cmp2_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Comparator results
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            office_res_q <= 1'b0;
            dark_res_q <= 1'b0;
        end else begin
            if (!office_en) begin
                office_res_q <= 1'b0;
            end else if (upd) begin
                office_res_q <= office_nxt;
            end
            if (!dark_en) begin
                dark_res_q <= 1'b0;
            end else if (upd) begin
                dark_res_q <= dark_nxt;
            end
        end
    end

    // Output registers
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
            office_cmp_o <= 1'b0;
            dark_cmp_o <= 1'b0;
            backlight_level_o <= `LEVEL_DAY;
        end else begin
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_d;
            end
            office_cmp_o <= office_res_q;
            dark_cmp_o <= dark_res_q;
            backlight_level_o <= level_d;
        end
    end

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    AST_FILT_TICK: assert property ((tick_q && $past(cnt_q) < $past(filt_limit)) |->
        $past(cnt_q) == $past(filt_limit) - 32'h1)
        else $error("Filter tick off interval");
    AST_FORCE_START: assert property ((idle && force_go) |=> conv_start_o ##1 !conv_start_o)
        else $error("Forced conversion not started");
    AST_FORCE_CLEAR: assert property ((force_clr && !wr_cfg) |=> !force_q)
        else $error("Force bit not cleared after conversion");
    AST_FORCE_IGNORE: assert property ((backlight_en_i && !force_q && !upd) |=> !force_q)
        else $error("Force accepted while backlight on");
    AST_CFG_READ: assert property ((reg_rd_i && reg_addr_i == `CFG2_ADDR) |=>
        reg_rdata_o[`DARK_RES_BIT] == $past(dark_res_q) && reg_rdata_o[`OFFICE_RES_BIT] == $past(office_res_q))
        else $error("Result bits wrong on read");
    AST_DARK_OFF: assert property (!dark_en |=> !dark_res_q ##1 !dark_cmp_o)
        else $error("Dark result set while disabled");
    AST_OFFICE_OFF: assert property (!office_en |=> !office_res_q)
        else $error("Office result set while disabled");
    AST_PRIORITY: assert property (dark_res_q |=> backlight_level_o == `LEVEL_DARK)
        else $error("Dark level lost priority");
    AST_OFFICE_TRIP: assert property ((upd && office_en && office_code_i < thr_q) |=> office_res_q)
        else $error("Office comparator failed to trip");
    AST_OFFICE_REL: assert property ((upd && office_en && office_res_q &&
        {1'b0, office_code_i} > {1'b0, thr_q} + {1'b0, office_hys_i}) |=> !office_res_q)
        else $error("Office comparator failed to release");
    AST_HOLD: assert property ((!upd && office_en) |=> $stable(office_res_q))
        else $error("Office result moved between conversions");
    AST_FORCE_SET: assert property (force_wr |=> force_q)
        else $error("Force request not latched");
    AST_PERIODIC_OFF: assert property ((tick_q && !backlight_en_i && !force_go) |=> !conv_start_o)
        else $error("Periodic conversion with backlight off");
    AST_START_PULSE: assert property (conv_start_o |=> !conv_start_o)
        else $error("Conversion start longer than one cycle");
    AST_LEVEL_OFFICE: assert property ((office_res_q && !dark_res_q) |=> backlight_level_o == `LEVEL_OFFICE)
        else $error("Office level not selected");
    AST_LEVEL_DAY: assert property ((!office_res_q && !dark_res_q) |=> backlight_level_o == `LEVEL_DAY)
        else $error("Daylight level not selected");
    AST_OFFICE_OUT: assert property (office_res_q |=> office_cmp_o)
        else $error("Office result not on output");
    AST_DARK_OUT: assert property (dark_res_q |=> dark_cmp_o)
        else $error("Dark result not on output");
    AST_THR_WRITE: assert property (wr_thr |=> thr_q == $past(reg_wdata_i))
        else $error("Office threshold write lost");
    AST_DARK_TRIP: assert property ((upd && dark_en && dark_code_i < dark_thr_i) |=> dark_res_q)
        else $error("Dark comparator failed to trip");

    COV_FORCED: cover property (force_clr);
    COV_OFFICE: cover property (backlight_level_o == `LEVEL_OFFICE);
    COV_DARK: cover property (backlight_level_o == `LEVEL_DARK);
    COV_PERIODIC: cover property (conv_start_o && backlight_en_i);
    COV_RELEASE: cover property (upd && office_res_q && !office_nxt);
endmodule // second_light_comparator_cfg
`default_nettype wire

// ===== tb/light_sensor_model.sv
// Phototransistor sensor model on the second light input
`timescale 1ns/1ns
`default_nettype none
module light_sensor_model (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic conv_start_i,
    input wire logic slow_i,
    input wire logic [7:0] office_lvl_i,
    input wire logic [7:0] dark_lvl_i,
    output logic conv_done_o,
    output logic [7:0] office_code_o,
    output logic [7:0] dark_code_o
);
    logic [3:0] cnt_q;
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q <= 4'h0;
        end else if (conv_start_i) begin
            cnt_q <= slow_i ? 4'h6 : 4'h1;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
    assign conv_done_o = (cnt_q == 4'h1);
    // Codes valid only with done
    assign office_code_o = conv_done_o ? office_lvl_i : ~office_lvl_i;
    assign dark_code_o = conv_done_o ? dark_lvl_i : ~dark_lvl_i;
endmodule // light_sensor_model
`default_nettype wire

// ===== tb/second_light_comparator_cfg_tb_top.sv
// Self-checking bench for the second light comparator block
`timescale 1ns/1ns
`default_nettype none
module second_light_comparator_cfg_tb_top;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic backlight_en_i = 1'b0;
    logic slow = 1'b0;
    logic [7:0] office_lvl = 8'h40;
    logic [7:0] dark_lvl = 8'h10;
    wire logic [7:0] reg_rdata_o, office_code, dark_code;
    wire logic [1:0] level;
    wire logic conv_start, conv_done, office_cmp, dark_cmp;
    logic [7:0] rd_v;
    int err_total = 0;
    int checks = 0;
    int n;
    int g;
    logic [7:0] rows [5][3] = '{'{8'h1D, 8'hEA, 8'hEA}, '{8'h1D, 8'h7F, 8'h7F},
        '{8'h1C, 8'hEF, 8'hE3}, '{8'h1C, 8'h0C, 8'h00}, '{8'h1E, 8'h55, 8'h00}};
    always #50 mclk_i = ~mclk_i;
    second_light_comparator_cfg #(.FILT_BASE_CYCLES(8)) second_light_comparator_cfg_inst (
        .mclk_i(mclk_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .sinks_active_i(1'b1), .backlight_en_i(backlight_en_i), .conv_done_i(conv_done),
        .office_code_i(office_code), .office_hys_i(8'h10), .dark_code_i(dark_code),
        .dark_thr_i(8'h20), .dark_hys_i(8'h04), .conv_start_o(conv_start),
        .office_cmp_o(office_cmp), .dark_cmp_o(dark_cmp), .backlight_level_o(level));
    light_sensor_model light_sensor_model_inst (.mclk_i(mclk_i), .reset_i(reset_i),
        .conv_start_i(conv_start), .slow_i(slow), .office_lvl_i(office_lvl), .dark_lvl_i(dark_lvl),
        .conv_done_o(conv_done), .office_code_o(office_code), .dark_code_o(dark_code));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge mclk_i);
        reg_wr_i = 1'b0;
        @(negedge mclk_i);
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge mclk_i);
        reg_rd_i = 1'b0;
        rd_v = reg_rdata_o;
        @(negedge mclk_i);
    endtask
    task automatic conv();
        n = 0;
        while (conv_done !== 1'b1 && n < 40) begin
            @(negedge mclk_i);
            n++;
        end
        if (n == 40) err_total++;
        repeat (3) @(negedge mclk_i);
    endtask
    task automatic gap();
        repeat (2) begin
            n = 0;
            @(negedge mclk_i);
            while (conv_start !== 1'b1 && n < 200) begin
                @(negedge mclk_i);
                n++;
            end
        end
        g = 0;
        do begin
            @(negedge mclk_i);
            g++;
        end while (conv_start !== 1'b1 && g < 200);
    endtask
    task automatic final_report();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #(20000 * 100);
        err_total++;
        final_report();
    end
    initial begin
        repeat (8) @(negedge mclk_i);
        reset_i = 1'b0;
        @(negedge mclk_i);
        check({6'h00, level}, 8'h01);
        rd(8'h1C);
        check(rd_v, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            wr(rows[i][0], rows[i][1]);
            rd(rows[i][0]);
            check(rd_v, rows[i][2]);
        end
        $display("test table done");
        wr(8'h1D, 8'h80);
        wr(8'h1C, 8'h13);
        conv();
        rd(8'h1C);
        check(rd_v, 8'h0F);
        check({6'h00, dark_cmp, office_cmp}, 8'h03);
        check({6'h00, level}, 8'h03);
        wr(8'h1C, 8'h01);
        rd(8'h1C);
        check(rd_v, 8'h05);
        check({6'h00, level}, 8'h02);
        office_lvl = 8'h90;
        wr(8'h1C, 8'h11);
        conv();
        rd(8'h1C);
        check(rd_v, 8'h05);
        office_lvl = 8'h91;
        wr(8'h1C, 8'h11);
        conv();
        rd(8'h1C);
        check(rd_v, 8'h01);
        check({6'h00, level}, 8'h01);
        slow = 1'b1;
        office_lvl = 8'h40;
        wr(8'h1C, 8'h12);
        conv();
        rd(8'h1C);
        check(rd_v, 8'h0A);
        $display("test forced done");
        backlight_en_i = 1'b1;
        wr(8'h1C, 8'h13);
        rd(8'h1C);
        check(rd_v & 8'h10, 8'h00);
        for (int s = 0; s < 3; s += 2) begin
            wr(8'h1C, 8'(s << 5) | 8'h03);
            gap();
            check(8'(g), 8'(8 << s));
        end
        $display("test filter done");
        reset_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        reset_i = 1'b0;
        @(negedge mclk_i);
        check({6'h00, level}, 8'h01);
        rd(8'h1C);
        check(rd_v, 8'h00);
        rd(8'h1D);
        check(rd_v, 8'h00);
        $display("test second reset done");
        final_report();
    end
endmodule // second_light_comparator_cfg_tb_top
`default_nettype wire
